// ### core/dlgt_pkg.sv
/*
  package of the lane gap timing controller: lane codes, transfer kinds,
  states and every timing count.
  assumes a 100 MHz ref_clk and a link clock made by dividing it by two.
*/
package dlgt_pkg;
  // ***********************************************
  // clock and timing
  // ***********************************************
  localparam int REF_PERIOD_NS = 10;
  localparam int UI_NS = 10;
  localparam int CLOCK_TRAIL_TIME_NS = 60;
  localparam int GAP_SHORT_NS = 150;
  localparam int GAP_LONG_UI = 32;
  localparam int GAP_LONG_NS = (GAP_SHORT_NS > GAP_LONG_UI * UI_NS) ?
                               GAP_SHORT_NS : GAP_LONG_UI * UI_NS;
  localparam int RST_HOLD_NS = 1000;
  localparam int BTA_TIMEOUT_NS = 10000;
  // least times round up to whole cycles
  localparam int TRAIL_CYC = (CLOCK_TRAIL_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS; // [RQ12]
  localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS; // [RQ12]
  localparam int GAP_LONG_CYC = (GAP_LONG_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS; // [RQ12]
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int BTA_TO_CYC = BTA_TIMEOUT_NS / REF_PERIOD_NS;
  localparam int TA_DRIVE_CYC = 2;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] TRAIL_CNT = CNT_W'(TRAIL_CYC);
  localparam logic [CNT_W-1:0] GAP_SHORT_CNT = CNT_W'(GAP_SHORT_CYC);
  localparam logic [CNT_W-1:0] GAP_LONG_CNT = CNT_W'(GAP_LONG_CYC);
  localparam logic [CNT_W-1:0] RST_HOLD_CNT = CNT_W'(RST_HOLD_CYC);
  localparam logic [CNT_W-1:0] BTA_TO_CNT = CNT_W'(BTA_TO_CYC);
  localparam logic [CNT_W-1:0] TA_DRIVE_CNT = CNT_W'(TA_DRIVE_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  // ***********************************************
  // lane codes and kinds
  // ***********************************************
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;
  typedef enum logic [1:0] {
    KIND_LP = 2'h0,
    KIND_HS = 2'h1,
    KIND_TA = 2'h2
  } dlgt_kind_t;
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_IDLE = 3'h1,
    ST_XFER = 3'h2,
    ST_TA_DRIVE = 3'h3,
    ST_TA_WAIT = 3'h4
  } dlgt_state_t;
endpackage

// ### core/dlgt_ctrl.sv
/*
  host side lane controller: paces escape, high speed and turnaround
  transfers on the link with stop state gaps, clock trail and reset hold.
  assumes a user that offers one transfer at a time and a peripheral that
  drives lane 0 during a turnaround.
*/
// Summary of operation
// [RQ1] the clock lane stays in high speed for the trail time after each burst ends.
// [RQ2] every new lane transfer is preceded by the stop state, even with a free running clock.
// [RQ3] the stop gap applies to all nine orderings of escape, burst and turnaround.
// [RQ4] escape after escape waits at least 150 ns of stop state.
// [RQ5] a burst after escape, burst or turnaround waits the larger of 150 ns and 32 UI.
// [RQ6] escape after a burst waits the larger of 150 ns and 32 UI.
// [RQ7] turnaround after turnaround waits at least 150 ns of stop state.
// [RQ8] turnaround after escape waits at least 150 ns of stop state.
// [RQ9] escape after turnaround waits at least 150 ns of stop state.
// [RQ10] turnaround after a burst waits the larger of 150 ns and 32 UI.
// [RQ11] all lanes sit in stop state while the module reset is held and released.
// [RQ12] the gap timer counts whole cycles rounded up so each gap is met.
`timescale 1ns/1ps
`default_nettype none
module dlgt_ctrl
  import dlgt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // user requests
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [7:0] req_len,
  input wire logic [7:0] req_data,
  output logic req_ready,
  input wire logic clk_continuous,
  output logic busy,
  output logic ta_timeout,
  // clock lane
  output logic lnk_clk_o,
  output logic clk_hs_en,
  output logic [1:0] clk_lp,
  // data lanes
  output logic dl_hs_en,
  output logic [7:0] dl_hs_data,
  output logic [1:0] dl_lp,
  output logic dl0_lp_oe_n,
  input wire logic [1:0] dl0_lp_in,
  // module reset
  output logic mod_rst_n
);
  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    dlgt_state_t st;
    dlgt_kind_t kind;
    dlgt_kind_t prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    logic [CNT_W-1:0] trail;
    logic [7:0] len;
    logic [7:0] data;
    logic clk_hs;
    logic div;
    logic dl_hs;
    logic [1:0] lp;
    logic oe_n;
    logic rst_n;
    logic seen_busy;
    logic timeout;
    logic [1:0] sy1;
    logic [1:0] sy2;
  } dlgt_regs_t;

  dlgt_regs_t s_r;
  dlgt_regs_t s_nxt;
  logic [CNT_W-1:0] need;
  logic start;

  // ***********************************************
  // gap needed for the offered transfer
  // ***********************************************
  always_comb
  begin
    if (s_r.prev == KIND_HS || req_kind == KIND_HS)
    begin
      need = GAP_LONG_CNT; // [RQ5] [RQ6] [RQ10]
    end
    else
    begin
      need = GAP_SHORT_CNT; // [RQ4] [RQ7] [RQ8] [RQ9]
    end
  end

  assign req_ready = (s_r.st == ST_IDLE) && (s_r.gap >= need) &&
                     (req_kind != 2'h3); // [RQ2] [RQ3]
  assign start = req_valid && req_ready;

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sy1 = dl0_lp_in;
    s_nxt.sy2 = s_r.sy1;
    s_nxt.div = ~s_r.div;
    if (s_r.gap != CNT_MAX && s_r.lp == LP11 && !s_r.dl_hs && !s_r.oe_n)
    begin
      s_nxt.gap = s_r.gap + 12'h001; // [RQ12]
    end
    if (s_r.trail != 12'h000)
    begin
      s_nxt.trail = s_r.trail - 12'h001;
    end
    else if (!clk_continuous && s_r.st != ST_XFER)
    begin
      s_nxt.clk_hs = 1'b0; // [RQ1]
    end
    if (clk_continuous && s_r.st != ST_RESET)
    begin
      s_nxt.clk_hs = 1'b1;
    end
    case (s_r.st)
      ST_RESET:
      begin
        s_nxt.lp = LP11; // [RQ11]
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.cnt == RST_HOLD_CNT)
        begin
          s_nxt.rst_n = 1'b1;
        end
        if (s_r.rst_n && s_r.cnt == RST_HOLD_CNT + RST_HOLD_CNT)
        begin
          s_nxt.st = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (start)
        begin
          s_nxt.kind = dlgt_kind_t'(req_kind);
          s_nxt.len = req_len;
          s_nxt.data = req_data;
          s_nxt.cnt = 12'h000;
          s_nxt.gap = 12'h000;
          s_nxt.timeout = 1'b0;
          if (req_kind == KIND_HS)
          begin
            s_nxt.st = ST_XFER;
            s_nxt.dl_hs = 1'b1;
            s_nxt.clk_hs = 1'b1;
            s_nxt.lp = LP00;
          end
          else if (req_kind == KIND_LP)
          begin
            s_nxt.st = ST_XFER;
            s_nxt.lp = LP10;
          end
          else
          begin
            s_nxt.st = ST_TA_DRIVE;
            s_nxt.lp = LP10;
          end
        end
      end
      ST_XFER:
      begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.kind == KIND_LP)
        begin
          s_nxt.lp = s_r.cnt[0] ? LP10 : LP01;
        end
        if (s_r.cnt >= {4'h0, s_r.len})
        begin
          s_nxt.st = ST_IDLE;
          s_nxt.lp = LP11; // [RQ2]
          s_nxt.dl_hs = 1'b0;
          s_nxt.prev = s_r.kind;
          if (s_r.kind == KIND_HS)
          begin
            s_nxt.trail = TRAIL_CNT; // [RQ1]
          end
        end
      end
      ST_TA_DRIVE:
      begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        s_nxt.lp = LP00;
        if (s_r.cnt == TA_DRIVE_CNT)
        begin
          s_nxt.st = ST_TA_WAIT;
          s_nxt.oe_n = 1'b1;
          s_nxt.seen_busy = 1'b0;
          s_nxt.cnt = 12'h000;
        end
      end
      ST_TA_WAIT:
      begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.sy2 != LP11)
        begin
          s_nxt.seen_busy = 1'b1;
        end
        if ((s_r.seen_busy && s_r.sy2 == LP11) || s_r.cnt == BTA_TO_CNT)
        begin
          s_nxt.st = ST_IDLE;
          s_nxt.oe_n = 1'b0;
          s_nxt.lp = LP11;
          s_nxt.prev = KIND_TA;
          s_nxt.timeout = !(s_r.seen_busy && s_r.sy2 == LP11);
        end
      end
      default:
      begin
        s_nxt.st = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.st <= ST_RESET;
      s_r.lp <= LP11;
      s_r.prev <= KIND_LP;
      s_r.kind <= KIND_LP;
      s_r.sy1 <= LP11;
      s_r.sy2 <= LP11;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign lnk_clk_o = s_r.div & s_r.clk_hs;
  assign clk_hs_en = s_r.clk_hs;
  assign clk_lp = s_r.clk_hs ? LP00 : LP11;
  assign dl_hs_en = s_r.dl_hs;
  assign dl_hs_data = s_r.dl_hs ? s_r.data : 8'h00;
  assign dl_lp = s_r.lp;
  assign dl0_lp_oe_n = s_r.oe_n;
  assign mod_rst_n = s_r.rst_n;
  assign busy = (s_r.st != ST_IDLE);
  assign ta_timeout = s_r.timeout;

  // ***********************************************
  // checks
  // ***********************************************
  logic [CNT_W-1:0] run_r;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      run_r <= 12'h000;
    end
    else if (dl_lp == LP11 && !dl_hs_en && !dl0_lp_oe_n)
    begin
      run_r <= (run_r == CNT_MAX) ? run_r : run_r + 12'h001;
    end
    else
    begin
      run_r <= 12'h000;
    end
  end

  sequence burst_end_s;
    $fell(dl_hs_en);
  endsequence
  sequence clock_held_s;
    clk_hs_en [*6];
  endsequence

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  trail_hold_a: assert property (burst_end_s |-> clock_held_s) // [RQ1]
    else $error("clock lane left high speed before trail time");
  stop_before_a: assert property ($changed(dl_lp) && $past(s_r.st) == ST_IDLE // [RQ2]
    |-> $past(dl_lp) == LP11)
    else $error("transfer began without stop state");
  gap_any_a: assert property (start |-> run_r >= GAP_SHORT_CNT) // [RQ3]
    else $error("gap below short minimum");
  gap_lp_lp_a: assert property (start && req_kind == KIND_LP && s_r.prev == KIND_LP // [RQ4]
    |-> run_r >= GAP_SHORT_CNT)
    else $error("escape to escape gap too short");
  gap_to_hs_a: assert property (start && req_kind == KIND_HS // [RQ5]
    |-> run_r >= GAP_LONG_CNT ##1 dl_hs_en)
    else $error("gap before burst too short");
  gap_hs_lp_a: assert property (start && req_kind == KIND_LP && s_r.prev == KIND_HS // [RQ6]
    |-> run_r >= GAP_LONG_CNT)
    else $error("burst to escape gap too short");
  gap_ta_ta_a: assert property (start && req_kind == KIND_TA && s_r.prev == KIND_TA // [RQ7]
    |-> run_r >= GAP_SHORT_CNT)
    else $error("turnaround to turnaround gap too short");
  gap_lp_ta_a: assert property (start && req_kind == KIND_TA && s_r.prev == KIND_LP // [RQ8]
    |-> run_r >= GAP_SHORT_CNT)
    else $error("escape to turnaround gap too short");
  gap_ta_lp_a: assert property (start && req_kind == KIND_LP && s_r.prev == KIND_TA // [RQ9]
    |-> run_r >= GAP_SHORT_CNT)
    else $error("turnaround to escape gap too short");
  gap_hs_ta_a: assert property (start && req_kind == KIND_TA && s_r.prev == KIND_HS // [RQ10]
    |-> run_r >= GAP_LONG_CNT)
    else $error("burst to turnaround gap too short");
  reset_idle_a: assert property (!mod_rst_n || $rose(mod_rst_n) // [RQ11]
    |-> dl_lp == LP11 && clk_lp == LP11 && !dl_hs_en)
    else $error("lanes not in stop state around module reset");
  exact_gap_a: assert property ($rose(req_ready) && $past(s_r.st) == ST_IDLE // [RQ12]
    && $stable(req_kind) |-> s_r.gap == need)
    else $error("gap timer released at wrong count");
endmodule // dlgt_ctrl
`default_nettype wire

// ### verif/dlgt_dev_model.sv
/*
  receiver side model of the link: answers a turnaround on lane 0 and
  measures the stop state before each start and the clock trail.
  assumes it sees the resolved lane 0 wire and the host lane outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module dlgt_dev_model
  import dlgt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // lanes at the pins
  input wire logic [1:0] dl_lp,
  input wire logic dl_hs_en,
  input wire logic clk_hs_en,
  input wire logic dl0_lp_oe_n,
  output logic [1:0] dev_lp,
  // measured times in ns
  output logic gap_v,
  output logic [15:0] gap_ns,
  output logic trail_v,
  output logic [15:0] trail_ns
);
  // ***********************************************
  // measurement and turnaround answer
  // ***********************************************
  int stop_c = 0;
  int trail_c = 0;
  int ta_c = 0;
  logic [1:0] lp_q;
  logic clk_q;
  always @(posedge ref_clk)
  begin
    gap_v <= 1'b0;
    trail_v <= 1'b0;
    lp_q <= dl_lp;
    clk_q <= clk_hs_en;
    // stop state time before each start
    if (!dl0_lp_oe_n && lp_q == LP11 && dl_lp != LP11)
    begin
      gap_v <= 1'b1;
      gap_ns <= 16'(stop_c * REF_PERIOD_NS);
    end
    stop_c <= (!dl0_lp_oe_n && dl_lp == LP11 && !dl_hs_en) ? stop_c + 1 : 0;
    // clock lane time in hs after the burst; a reset drop is not a trail
    trail_c <= (clk_hs_en && !dl_hs_en) ? trail_c + 1 : 0;
    if (clk_q && !clk_hs_en && rstn)
    begin
      trail_v <= 1'b1;
      trail_ns <= 16'(trail_c * REF_PERIOD_NS);
    end
    // answer a turnaround with LP-00 then hand back in LP-11
    ta_c <= dl0_lp_oe_n ? ta_c + 1 : 0;
    dev_lp <= (ta_c >= 2 && ta_c < 5) ? LP00 : LP11;
  end
endmodule // dlgt_dev_model
`default_nettype wire

// ### verif/test_dlgt_ctrl.sv
/*
  self checking bench of the lane controller with a receiver model.
  assumes the design package and a 100 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dlgt_ctrl
  import dlgt_pkg::*;
;
  // ***********************************************
  // signals and instances
  // ***********************************************
  logic ref_clk, rstn, req_valid = 0, clk_continuous = 0;
  logic [1:0] req_kind = 0, clk_lp, dl_lp, dev_lp, prev_k;
  logic [7:0] req_len = 0, req_data = 0, dl_hs_data;
  logic req_ready, busy, ta_timeout, lnk_clk_o, clk_hs_en, dl_hs_en;
  logic dl0_lp_oe_n, mod_rst_n, gap_v, trail_v, first;
  logic [15:0] gap_ns, trail_ns;
  wire [1:0] dl0_wire = dl0_lp_oe_n ? dev_lp : dl_lp;
  int fails = 0, cmp_count = 0, seed = 30;
  int gap_q[$], trail_q[$];
  logic [7:0] data_q[$];
  dlgt_ctrl uut (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
    .req_kind(req_kind), .req_len(req_len), .req_data(req_data),
    .req_ready(req_ready), .clk_continuous(clk_continuous), .busy(busy),
    .ta_timeout(ta_timeout), .lnk_clk_o(lnk_clk_o), .clk_hs_en(clk_hs_en),
    .clk_lp(clk_lp), .dl_hs_en(dl_hs_en), .dl_hs_data(dl_hs_data),
    .dl_lp(dl_lp), .dl0_lp_oe_n(dl0_lp_oe_n), .dl0_lp_in(dl0_wire),
    .mod_rst_n(mod_rst_n));
  dlgt_dev_model dev (.ref_clk(ref_clk), .rstn(rstn), .dl_lp(dl0_wire),
    .dl_hs_en(dl_hs_en), .clk_hs_en(clk_hs_en), .dl0_lp_oe_n(dl0_lp_oe_n),
    .dev_lp(dev_lp), .gap_v(gap_v), .gap_ns(gap_ns), .trail_v(trail_v),
    .trail_ns(trail_ns));
  // ***********************************************
  // tasks
  // ***********************************************
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk_eq(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_ge(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if ((got >= exp) !== 1'b1)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rst_cycle;
    rstn = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_eq({11'h0, dl_lp, clk_lp, mod_rst_n}, {11'h0, LP11, LP11, 1'b0});
    rstn = 1'b1;
    repeat (50) @(posedge ref_clk);
    #1;
    chk_eq({11'h0, dl_lp, clk_lp, mod_rst_n}, {11'h0, LP11, LP11, 1'b0});
    first = 1'b1;
  endtask
  task send(input logic [1:0] k);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b1;
    req_kind = k;
    req_len = 8'($random(seed)) & 8'h07;
    req_data = 8'($random(seed));
    while (req_ready !== 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 2000)
      fails++;
    chk_eq({14'h0, busy, ta_timeout}, 16'h0000);
    gap_q.push_back(first ? 0 : ((prev_k == KIND_HS || k == KIND_HS) ?
      GAP_LONG_NS : GAP_SHORT_NS));
    if (k == KIND_HS && !clk_continuous)
      trail_q.push_back(CLOCK_TRAIL_TIME_NS);
    if (k == KIND_HS)
      repeat (int'(req_len) + 1) data_q.push_back(req_data);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    chk_eq({15'h0, busy}, 16'h0001);
    prev_k = k;
    first = 1'b0;
  endtask
  // ***********************************************
  // clock, checker, watchdog and sequence
  // ***********************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (gap_v === 1'b1)
      chk_ge(gap_ns, 16'(gap_q.pop_front()));
    if (trail_v === 1'b1)
      chk_ge(trail_ns, 16'(trail_q.pop_front()));
    if (dl_hs_en === 1'b1)
      chk_eq({8'h00, dl_hs_data}, {8'h00, data_q.pop_front()});
    if (clk_hs_en === 1'b0)
      chk_eq({13'h0, lnk_clk_o, clk_lp}, {13'h0, 1'b0, LP11});
  end
  initial
  begin
    #200000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    rst_cycle;
    for (int a = 0; a < 3; a++)
      for (int b = 0; b < 3; b++)
      begin
        send(2'(a));
        send(2'(b));
      end
    // the unused kind code is never taken
    @(posedge ref_clk);
    #1;
    req_valid = 1'b1;
    req_kind = 2'h3;
    repeat (40) @(posedge ref_clk);
    #1;
    chk_eq({14'h0, req_ready, busy}, 16'h0000);
    req_valid = 1'b0;
    clk_continuous = 1'b1;
    repeat (12) send(2'($unsigned($random(seed)) % 3));
    repeat (100) @(posedge ref_clk);
    #1;
    rst_cycle;
    report_and_stop;
  end
endmodule // test_dlgt_ctrl
`default_nettype wire
